// ==== cmu_pkg.sv ====
package cmu_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ  = 50000000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

  // Times in their own units
  localparam int unsigned IDLE_S        = 60;
  localparam int unsigned REPEAT_S      = 1;
  localparam int unsigned LONG_S        = 2;
  localparam int unsigned SHOW_S        = 2;
  localparam int unsigned FAST_AFTER_MS = 2000;
  localparam int unsigned SLOW_STEP_MS  = 200;
  localparam int unsigned FAST_STEP_MS  = 50;
  localparam int unsigned BRIEF_MS      = 500;

  // Times in clock cycles
  localparam int unsigned IDLE_CYC       = IDLE_S * CLK_HZ;
  localparam int unsigned REPEAT_CYC     = REPEAT_S * CLK_HZ;
  localparam int unsigned LONG_CYC       = LONG_S * CLK_HZ;
  localparam int unsigned SHOW_CYC       = SHOW_S * CLK_HZ;
  localparam int unsigned FAST_AFTER_CYC = REPEAT_CYC + FAST_AFTER_MS * CLK_KHZ;
  localparam int unsigned SLOW_STEP_CYC  = SLOW_STEP_MS * CLK_KHZ;
  localparam int unsigned FAST_STEP_CYC  = FAST_STEP_MS * CLK_KHZ;
  localparam int unsigned BRIEF_CYC      = BRIEF_MS * CLK_KHZ;

  // Value limits and step, signed 16 bit; unity gain 32 bit
  localparam logic signed [15:0] DISP_LO = 16'hF831;
  localparam logic signed [15:0] DISP_HI = 16'h270F;
  localparam logic signed [15:0] GAIN_LO = 16'hD8F1;
  localparam logic signed [15:0] GAIN_HI = 16'h270F;
  localparam logic signed [15:0] ONE_S   = 16'h0001;
  localparam logic signed [31:0] GAIN_ONE = 32'h00002710;

  // Register byte offsets
  localparam logic [7:0] REG_ZERO    = 8'h00;
  localparam logic [7:0] REG_GAIN    = 8'h04;
  localparam logic [7:0] REG_CONFIG  = 8'h08;
  localparam logic [7:0] REG_SWITCH  = 8'h0C;
  localparam logic [7:0] REG_ALARM   = 8'h10;
  localparam logic [7:0] REG_MINREC  = 8'h14;
  localparam logic [7:0] REG_MAXREC  = 8'h18;
  localparam logic [7:0] REG_SHOWN   = 8'h1C;
  localparam logic [7:0] REG_STATUS  = 8'h20;
  localparam logic [7:0] REG_UID     = 8'h24;
  localparam logic [7:0] REG_BUSADDR = 8'h28;

  // Field layout and reset values
  localparam int unsigned CFG_W       = 8;
  localparam int unsigned ADDR_W      = 8;
  localparam logic [31:0] SWITCH_DEF  = 32'h00C80064;
  localparam logic [31:0] ALARM_DEF   = 32'h01F40000;
  localparam logic [7:0]  BUSADDR_DEF = 8'h01;
  // Arbitrary identification value
  localparam logic [31:0] UID_DEF     = 32'h5A3C0001;

  typedef enum logic [3:0] {
    ST_RUN    = 4'b0000,
    ST_ZERO_P = 4'b0001,
    ST_ZERO_E = 4'b0010,
    ST_GAIN_P = 4'b0011,
    ST_GAIN_E = 4'b0100,
    ST_MIN_P  = 4'b0101,
    ST_MIN_S  = 4'b0110,
    ST_MAX_P  = 4'b0111,
    ST_MAX_S  = 4'b1000,
    ST_WIPE_P = 4'b1001
  } cmu_state_type;

  typedef enum logic [2:0] {
    PR_NONE = 3'b000,
    PR_ZERO = 3'b001,
    PR_GAIN = 3'b010,
    PR_MIN  = 3'b011,
    PR_MAX  = 3'b100,
    PR_WIPE = 3'b101
  } cmu_prompt_type;

endpackage : cmu_pkg

// ==== cmu_button.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmu_button
  import cmu_pkg::*;
#(
  parameter int unsigned REP_CYC  = REPEAT_CYC,
  parameter int unsigned FAST_CYC = FAST_AFTER_CYC,
  parameter int unsigned SLOW_PER = SLOW_STEP_CYC,
  parameter int unsigned FAST_PER = FAST_STEP_CYC,
  parameter int unsigned LONG_THR = LONG_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Raw pin, high while pressed
  input  wire logic btn_pin,
  // Decoded events
  output logic      held,
  output logic      step,
  output logic      long_hit,
  output logic      short_rel
);

  logic        meta_q;
  logic        sync_q;
  logic        prev_q;
  logic [31:0] hold_q;
  logic [31:0] rep_q;

  wire         press   = sync_q & ~prev_q;
  wire         rel_w   = ~sync_q & prev_q;
  wire         rolling = sync_q & (hold_q >= REP_CYC);
  wire         fast    = hold_q >= FAST_CYC;
  wire  [31:0] period  = fast ? FAST_PER : SLOW_PER;
  wire         tick    = rolling & (rep_q >= period - 32'h1);

  assign held      = sync_q;
  // Roll speeds up once the hold passes the fast mark
  assign step      = press | tick; // [R03] [R04]
  assign long_hit  = sync_q & (hold_q == LONG_THR - 32'h1); // [R18]
  assign short_rel = rel_w & (hold_q < LONG_THR); // [R18]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      hold_q <= 32'h0;
      rep_q  <= 32'h0;
    end else begin
      meta_q <= btn_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
      if (!sync_q) begin
        hold_q <= 32'h0;
      end else if (hold_q != 32'hFFFFFFFF) begin
        hold_q <= hold_q + 32'h1;
      end
      rep_q <= (!rolling || tick) ? 32'h0 : rep_q + 32'h1;
    end
  end

endmodule : cmu_button
`default_nettype wire

// ==== cmu_calib_ui.sv ====
// Operation
// R01 - Menu idle 60 s: leave, discard edits
// R02 - Kind or probe change restores defaults
// R03 - Single up or down press steps one
// R04 - Hold over 1 s rolls, then faster
// R05 - Edited value wraps between its limits
// R06 - Down held 2 s opens zero shift prompt
// R07 - Select stores zero shift, next goes gain
// R08 - Zero shift subtracted from measured value
// R09 - Shown equals difference times one plus gain
// R10 - Gain in percent, select stores it
// R11 - Keep highest and lowest since clear
// R12 - Short down: min prompt, minimum 2 s
// R13 - Short up: max prompt, maximum 2 s
// R14 - Both held 2 s: wipe, load shown value
// R15 - Answer only host requests, never unasked
// R16 - Hold a unique identification number
// R17 - Host assigns bus address, device adopts it
// R18 - Release before threshold short, else long
// R19 - Compare each shown value with records
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module cmu_calib_ui
  import cmu_pkg::*;
#(
  parameter int unsigned IDLE_T    = IDLE_CYC,
  parameter int unsigned REP_T     = REPEAT_CYC,
  parameter int unsigned FAST_T    = REP_T * (FAST_AFTER_CYC / REPEAT_CYC),
  parameter int unsigned SLOW_P    = SLOW_STEP_CYC,
  parameter int unsigned FAST_P    = SLOW_P / (SLOW_STEP_CYC / FAST_STEP_CYC),
  parameter int unsigned LONG_T    = LONG_CYC,
  parameter int unsigned SHOW_T    = LONG_T * (SHOW_CYC / LONG_CYC),
  parameter int unsigned BRIEF_T   = BRIEF_CYC,
  parameter logic [31:0] UNIT_ID   = UID_DEF
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Front panel buttons, high while pressed
  input  wire logic               btn_sel,
  input  wire logic               btn_up,
  input  wire logic               btn_dn,
  // Measured value from the converter logic
  input  wire logic signed [15:0] meas_value,
  input  wire logic               meas_valid,
  // Display
  output logic      [15:0]        disp_value,
  output logic      [2:0]         disp_prompt,
  // Serial bus identity
  output logic      [ADDR_W-1:0]  bus_addr
);

  function automatic logic signed [15:0] wrap_step(input logic signed [15:0] v,
                                                   input logic up,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
    if (up) begin
      wrap_step = (v >= hi) ? lo : 16'(v + ONE_S); // [R05]
    end else begin
      wrap_step = (v <= lo) ? hi : 16'(v - ONE_S); // [R05]
    end
  endfunction : wrap_step

  cmu_state_type      st_q, st_d;
  logic signed [15:0] edit_q, edit_d;
  logic signed [15:0] zero_q;
  logic signed [15:0] gain_q;
  logic signed [15:0] shown_q;
  logic signed [15:0] min_q;
  logic signed [15:0] max_q;
  logic               rec_ok_q;
  logic               upd_q;
  logic               lock_q, lock_d;
  logic               combo_q;
  logic [31:0]        combo_cnt_q;
  logic [31:0]        tmr_q;
  logic [31:0]        idle_q;
  logic [CFG_W-1:0]   cfg_q;
  logic [31:0]        switch_q;
  logic [31:0]        alarm_q;
  logic               tmr_clr;
  logic               wipe_go;
  logic               zero_st;
  logic               gain_st;
  logic [31:0]        rd_mux;
  logic               hit;
  cmu_prompt_type     pr_w;
  logic signed [15:0] val_w;

  // Button decoding
  logic up_held, up_step, up_long, up_short;
  logic dn_held, dn_step, dn_long, dn_short;
  logic sel_held, sel_press;

  cmu_button #(.REP_CYC(REP_T), .FAST_CYC(FAST_T), .SLOW_PER(SLOW_P),
               .FAST_PER(FAST_P), .LONG_THR(LONG_T)) u_up (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .btn_pin   (btn_up),
    .held      (up_held),
    .step      (up_step),
    .long_hit  (up_long),
    .short_rel (up_short)
  );

  cmu_button #(.REP_CYC(REP_T), .FAST_CYC(FAST_T), .SLOW_PER(SLOW_P),
               .FAST_PER(FAST_P), .LONG_THR(LONG_T)) u_dn (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .btn_pin   (btn_dn),
    .held      (dn_held),
    .step      (dn_step),
    .long_hit  (dn_long),
    .short_rel (dn_short)
  );

  cmu_button #(.REP_CYC(REP_T), .FAST_CYC(FAST_T), .SLOW_PER(SLOW_P),
               .FAST_PER(FAST_P), .LONG_THR(LONG_T)) u_sel (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .btn_pin   (btn_sel),
    .held      (sel_held),
    .step      (sel_press),
    .long_hit  (),
    .short_rel ()
  );

  wire any_held   = up_held | dn_held | sel_held;
  wire one_step   = (up_step ^ dn_step) & ~lock_q;
  wire sel_go     = sel_press & ~lock_q;
  wire timeout    = idle_q >= IDLE_T - 32'h1;
  wire brief_done = tmr_q >= BRIEF_T - 32'h1;
  wire show_done  = tmr_q >= SHOW_T - 32'h1;
  wire combo_long = up_held & dn_held & (combo_cnt_q == LONG_T - 32'h1);

  // Correction path: diff is 17 bit, product stays inside 32 bit while gain_q is within GAIN_LO to GAIN_HI
  wire signed [16:0] diff   = 17'(meas_value) - 17'(zero_q); // [R08]
  wire signed [31:0] factor = GAIN_ONE + 32'(gain_q);
  wire signed [31:0] prod   = 32'(diff) * factor; // [R09]
  wire signed [31:0] scaled = prod / GAIN_ONE; // [R09]
  wire signed [15:0] clamped = (scaled > 32'(DISP_HI)) ? DISP_HI :
                               (scaled < 32'(DISP_LO)) ? DISP_LO : 16'(scaled);

  // APB handshake: one wait state, then completion
  wire acc     = psel & penable;
  wire acc_1st = acc & ~pready;
  wire done    = acc & pready;
  wire wr_done = done & pwrite;
  wire cfg_wr  = wr_done & (paddr == REG_CONFIG);
  wire cfg_chg = cfg_wr & (pwdata[CFG_W-1:0] != cfg_q);

  // Menu sequencing
  always_comb begin
    st_d    = st_q;
    edit_d  = edit_q;
    lock_d  = lock_q & any_held;
    tmr_clr = 1'b0;
    wipe_go = 1'b0;
    zero_st = 1'b0;
    gain_st = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (combo_long) begin
          st_d = ST_WIPE_P; // [R14]
        end else if (dn_long & ~combo_q & ~up_held) begin
          st_d   = ST_ZERO_P; // [R06]
          lock_d = 1'b1;
        end else if (dn_short & ~combo_q) begin
          st_d = ST_MIN_P; // [R12] [R18]
        end else if (up_short & ~combo_q) begin
          st_d = ST_MAX_P; // [R13] [R18]
        end
      end
      ST_MIN_P: if (brief_done) st_d = ST_MIN_S; // [R12]
      ST_MIN_S: if (show_done) st_d = ST_RUN; // [R12]
      ST_MAX_P: if (brief_done) st_d = ST_MAX_S; // [R13]
      ST_MAX_S: if (show_done) st_d = ST_RUN; // [R13]
      ST_WIPE_P: begin
        if (brief_done) begin
          st_d    = ST_RUN;
          wipe_go = 1'b1; // [R14]
        end
      end
      ST_ZERO_P: begin
        if (timeout) begin
          st_d = ST_RUN; // [R01]
        end else if (sel_go) begin
          st_d = ST_GAIN_P; // [R07]
        end else if (one_step) begin
          st_d   = ST_ZERO_E;
          edit_d = wrap_step(zero_q, up_step, DISP_LO, DISP_HI); // [R03]
        end
      end
      ST_ZERO_E: begin
        if (timeout) begin
          st_d = ST_RUN; // [R01]
        end else if (sel_go) begin
          st_d    = ST_ZERO_P;
          zero_st = 1'b1; // [R07]
        end else if (one_step) begin
          edit_d = wrap_step(edit_q, up_step, DISP_LO, DISP_HI); // [R03] [R05]
        end
      end
      ST_GAIN_P: begin
        if (timeout || sel_go) begin
          st_d = ST_RUN; // [R01]
        end else if (one_step) begin
          st_d   = ST_GAIN_E;
          edit_d = wrap_step(gain_q, up_step, GAIN_LO, GAIN_HI); // [R10]
        end
      end
      ST_GAIN_E: begin
        if (timeout) begin
          st_d = ST_RUN; // [R01]
        end else if (sel_go) begin
          st_d    = ST_GAIN_P;
          gain_st = 1'b1; // [R10]
        end else if (one_step) begin
          edit_d = wrap_step(edit_q, up_step, GAIN_LO, GAIN_HI); // [R05]
        end
      end
      default: st_d = ST_RUN;
    endcase
    if (st_d != st_q) begin
      tmr_clr = 1'b1;
    end
  end

  // Display selection
  assign val_w = (st_q == ST_RUN)    ? shown_q :
                 (st_q == ST_ZERO_E) ? edit_q :
                 (st_q == ST_GAIN_E) ? edit_q :
                 (st_q == ST_MIN_S)  ? min_q :
                 (st_q == ST_MAX_S)  ? max_q : 16'h0000;
  assign pr_w  = (st_q == ST_ZERO_P) ? PR_ZERO :
                 (st_q == ST_GAIN_P) ? PR_GAIN :
                 (st_q == ST_MIN_P)  ? PR_MIN :
                 (st_q == ST_MAX_P)  ? PR_MAX :
                 (st_q == ST_WIPE_P) ? PR_WIPE : PR_NONE;

  // Register read decode
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0;
    if (paddr == REG_ZERO) begin
      rd_mux = 32'(zero_q);
    end else if (paddr == REG_GAIN) begin
      rd_mux = 32'(gain_q);
    end else if (paddr == REG_CONFIG) begin
      rd_mux = 32'(cfg_q);
    end else if (paddr == REG_SWITCH) begin
      rd_mux = switch_q;
    end else if (paddr == REG_ALARM) begin
      rd_mux = alarm_q;
    end else if (paddr == REG_MINREC) begin
      rd_mux = 32'(min_q);
    end else if (paddr == REG_MAXREC) begin
      rd_mux = 32'(max_q);
    end else if (paddr == REG_SHOWN) begin
      rd_mux = 32'(shown_q);
    end else if (paddr == REG_STATUS) begin
      rd_mux = {26'h0, rec_ok_q, lock_q, st_q};
    end else if (paddr == REG_UID) begin
      rd_mux = UNIT_ID; // [R16]
    end else if (paddr == REG_BUSADDR) begin
      rd_mux = 32'(bus_addr);
    end else begin
      hit = 1'b0;
    end
  end

  // Bus slave: data and ready only inside a host transfer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc_1st; // [R15]
      pslverr <= acc_1st & ~hit;
      prdata  <= (acc_1st & ~pwrite) ? rd_mux : 32'h0; // [R15]
    end
  end

  // Settings written by the host
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q    <= '0;
      switch_q <= SWITCH_DEF;
      alarm_q  <= ALARM_DEF;
      bus_addr <= BUSADDR_DEF;
    end else begin
      if (cfg_wr) cfg_q <= pwdata[CFG_W-1:0];
      if (cfg_chg) begin
        switch_q <= SWITCH_DEF; // [R02]
        alarm_q  <= ALARM_DEF; // [R02]
      end else if (wr_done && paddr == REG_SWITCH) begin
        switch_q <= pwdata;
      end else if (wr_done && paddr == REG_ALARM) begin
        alarm_q <= pwdata;
      end
      if (wr_done && paddr == REG_BUSADDR) bus_addr <= pwdata[ADDR_W-1:0]; // [R17]
    end
  end

  // Calibration values; a panel store wins over a host write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zero_q <= 16'h0000;
      gain_q <= 16'h0000;
    end else begin
      if (zero_st) zero_q <= edit_q; // [R07]
      else if (wr_done && paddr == REG_ZERO) zero_q <= pwdata[15:0];
      if (gain_st) gain_q <= edit_q; // [R10]
      else if (wr_done && paddr == REG_GAIN) gain_q <= pwdata[15:0];
    end
  end

  // Menu state and timers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q        <= ST_RUN;
      edit_q      <= 16'h0000;
      lock_q      <= 1'b0;
      combo_q     <= 1'b0;
      combo_cnt_q <= 32'h0;
      tmr_q       <= 32'h0;
      idle_q      <= 32'h0;
    end else begin
      st_q        <= st_d;
      edit_q      <= edit_d;
      lock_q      <= lock_d;
      // A combo hold must not also count as a short press on release
      combo_q     <= (combo_q & (up_held | dn_held)) | (up_held & dn_held);
      combo_cnt_q <= (up_held & dn_held) ? combo_cnt_q + 32'h1 : 32'h0; // [R14]
      tmr_q       <= tmr_clr ? 32'h0 : tmr_q + 32'h1;
      idle_q      <= (any_held || st_q == ST_RUN) ? 32'h0 : idle_q + 32'h1; // [R01]
    end
  end

  // Shown value and extreme records
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shown_q  <= 16'h0000;
      upd_q    <= 1'b0;
      min_q    <= 16'h0000;
      max_q    <= 16'h0000;
      rec_ok_q <= 1'b0;
    end else begin
      upd_q <= meas_valid;
      if (meas_valid) shown_q <= clamped; // [R09]
      if (wipe_go) begin
        min_q    <= shown_q; // [R14]
        max_q    <= shown_q; // [R14]
        rec_ok_q <= 1'b1;
      end else if (upd_q) begin
        rec_ok_q <= 1'b1;
        if (!rec_ok_q || shown_q < min_q) min_q <= shown_q; // [R11] [R19]
        if (!rec_ok_q || shown_q > max_q) max_q <= shown_q; // [R11] [R19]
      end
    end
  end

  // Display outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disp_value  <= 16'h0000;
      disp_prompt <= PR_NONE;
    end else begin
      disp_value  <= val_w;
      disp_prompt <= pr_w;
    end
  end

endmodule : cmu_calib_ui
`default_nettype wire

// ==== cmu_calib_ui_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmu_calib_ui_monitor
  import cmu_pkg::*;
#(
  parameter logic [31:0] UNIT_ID = UID_DEF
) (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Panel and measurement
  input wire logic               btn_sel,
  input wire logic               btn_up,
  input wire logic               btn_dn,
  input wire logic signed [15:0] meas_value,
  input wire logic               meas_valid,
  input wire logic [15:0]        disp_value,
  input wire logic [2:0]         disp_prompt,
  input wire logic [ADDR_W-1:0]  bus_addr
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire       acc_w     = psel && penable;
  wire       done_w    = acc_w && pready;
  wire [7:0] wr_byte_w = pwdata[7:0];
  wire       addr_wr_w = done_w && pwrite && !pslverr && (paddr == REG_BUSADDR);

  answer_wait_a: assert property (acc_w && !pready |=> pready) else $error("no answer");
  asked_only_a: assert property (pready |-> acc_w) else $error("unasked answer");
  pulse_once_a: assert property (pready |=> !pready) else $error("answer held");
  rdata_quiet_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  unmapped_err_a: assert property (done_w && paddr > REG_BUSADDR |-> pslverr && prdata == 32'h0)
    else $error("unmapped accepted");
  mapped_ok_a: assert property (done_w && paddr <= REG_BUSADDR && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  uid_read_a: assert property (done_w && !pwrite && paddr == REG_UID |-> prdata == UNIT_ID)
    else $error("identity wrong");
  addr_adopt_a: assert property (addr_wr_w |=> bus_addr == $past(wr_byte_w))
    else $error("address not adopted");
  addr_hold_a: assert property (!addr_wr_w |=> $stable(bus_addr)) else $error("address moved");
  wipe_seen_c: cover property (disp_prompt == PR_WIPE);
endmodule : cmu_calib_ui_monitor

bind cmu_calib_ui cmu_calib_ui_monitor #(.UNIT_ID(UNIT_ID)) mon_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .btn_sel(btn_sel), .btn_up(btn_up), .btn_dn(btn_dn), .meas_value(meas_value),
  .meas_valid(meas_valid), .disp_value(disp_value), .disp_prompt(disp_prompt),
  .bus_addr(bus_addr));
`default_nettype wire

// ==== cmu_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cmu_host_model (
  // Clock
  input  wire logic        ref_clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'hFFFFFFFF;
  end
  // Host polls; the device only ever answers a request
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output bit ok);
    int n;
    ok = 1'b0;
    rdata = 32'h0;
    err = 1'b0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rdata = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so stale values are never mistaken for data
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask : xfer
endmodule : cmu_host_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cmu_pkg::*;
  typedef struct packed {
    logic [15:0] meas;
    logic [15:0] zero;
    logic [15:0] gain;
    logic [15:0] shown;
  } cmu_row_type;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic btn_sel = 1'b0, btn_up = 1'b0, btn_dn = 1'b0, meas_valid = 1'b0;
  logic signed [15:0] meas_value = 16'h0000;
  logic [15:0] disp_value;
  logic [2:0] disp_prompt;
  logic [7:0] bus_addr;
  int miscompares = 0;
  int tests_run = 0;
  int i;
  cmu_row_type rows [0:5] = '{
    '{16'h03E8, 16'h0000, 16'h00C8, 16'h03FC}, '{16'h0066, 16'h0002, 16'h0000, 16'h0064},
    '{16'h0651, 16'h0000, 16'hFF97, 16'h0640}, '{16'h2328, 16'hFC18, 16'h0000, 16'h270F},
    '{16'hFA24, 16'h03E8, 16'h0000, 16'hF831}, '{16'h01F4, 16'h0000, 16'h0000, 16'h01F4}};
  always #10 ref_clk = ~ref_clk;
  cmu_host_model cmu_host_model_i (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Short counts keep the run small; order REP_T < LONG_T < IDLE_T is kept
  cmu_calib_ui #(.IDLE_T(200), .REP_T(20), .SLOW_P(8), .LONG_T(40),
    .BRIEF_T(10)) cmu_calib_ui_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_sel(btn_sel), .btn_up(btn_up), .btn_dn(btn_dn),
    .meas_value(meas_value), .meas_valid(meas_valid), .disp_value(disp_value),
    .disp_prompt(disp_prompt), .bus_addr(bus_addr));
  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sx
  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic hang;
    miscompares++;
    close_out();
  endtask : hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    bit ok;
    cmu_host_model_i.xfer(wr, a, d, r, e, ok);
    if (!ok) hang();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    bus(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
  endtask : rd
  task automatic measure(input logic [15:0] v);
    @(posedge ref_clk);
    meas_value <= v;
    meas_valid <= 1'b1;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : measure
  task automatic wait_prompt(input logic [2:0] p, input int bound);
    int n;
    for (n = 0; n < bound && disp_prompt !== p; n++) @(posedge ref_clk);
    if (disp_prompt !== p) hang();
  endtask : wait_prompt
  // Buttons as {sel, up, dn}, held n cycles, then time for the input sync pipeline
  task automatic press(input logic [2:0] b, input int n);
    @(posedge ref_clk);
    {btn_sel, btn_up, btn_dn} <= b;
    repeat (n) @(posedge ref_clk);
    {btn_sel, btn_up, btn_dn} <= 3'b000;
    repeat (8) @(posedge ref_clk);
  endtask : press
  task automatic enter_menu;
    @(posedge ref_clk);
    btn_dn <= 1'b1;
    wait_prompt(PR_ZERO, 80);
    btn_dn <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : enter_menu
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    check("addr reset", {24'h0, bus_addr}, 32'h1);
    rd("switch", REG_SWITCH, SWITCH_DEF);
    wr(REG_SWITCH, 32'h12345678);
    rd("switch rw", REG_SWITCH, 32'h12345678);
    wr(REG_CONFIG, 32'h11);
    rd("switch def", REG_SWITCH, SWITCH_DEF);
    rd("alarm def", REG_ALARM, ALARM_DEF);
    wr(REG_UID, 32'h0);
    rd("uid", REG_UID, UID_DEF);
    rd("unmapped", 8'h40, 32'h0);
    wr(REG_BUSADDR, 32'h37);
    rd("addr reg", REG_BUSADDR, 32'h37);
    check("addr", {24'h0, bus_addr}, 32'h37);
    $display("test registers done");
    for (i = 0; i < 6; i++) begin
      wr(REG_ZERO, sx(rows[i].zero));
      wr(REG_GAIN, sx(rows[i].gain));
      measure(rows[i].meas);
      rd("shown", REG_SHOWN, sx(rows[i].shown));
      check("disp", {16'h0, disp_value}, {16'h0, rows[i].shown});
    end
    rd("min", REG_MINREC, sx(16'hF831));
    rd("max", REG_MAXREC, sx(16'h270F));
    $display("test correction done");
    press(3'b010, 4);
    wait_prompt(PR_MAX, 30);
    wait_prompt(PR_NONE, 40);
    repeat (2) @(posedge ref_clk);
    check("max shown", {16'h0, disp_value}, 32'h270F);
    repeat (40) @(posedge ref_clk);
    press(3'b001, 4);
    wait_prompt(PR_MIN, 30);
    wait_prompt(PR_NONE, 40);
    repeat (2) @(posedge ref_clk);
    check("min shown", {16'h0, disp_value}, 32'hF831);
    repeat (40) @(posedge ref_clk);
    @(posedge ref_clk);
    {btn_up, btn_dn} <= 2'b11;
    wait_prompt(PR_WIPE, 80);
    {btn_up, btn_dn} <= 2'b00;
    repeat (30) @(posedge ref_clk);
    rd("wipe min", REG_MINREC, 32'h1F4);
    rd("wipe max", REG_MAXREC, 32'h1F4);
    $display("test records done");
    enter_menu();
    press(3'b010, 4);
    check("step up", {16'h0, disp_value}, 32'h1);
    press(3'b001, 4);
    press(3'b001, 4);
    check("step dn", {16'h0, disp_value}, 32'hFFFF);
    press(3'b100, 4);
    check("zero prompt", {29'h0, disp_prompt}, {29'h0, PR_ZERO});
    rd("zero", REG_ZERO, 32'hFFFFFFFF);
    press(3'b010, 4);
    repeat (220) @(posedge ref_clk);
    check("idle exit", {29'h0, disp_prompt}, {29'h0, PR_NONE});
    rd("zero kept", REG_ZERO, 32'hFFFFFFFF);
    $display("test menu done");
    wr(REG_ZERO, 32'h270F);
    enter_menu();
    press(3'b010, 4);
    check("wrap hi", {16'h0, disp_value}, 32'hF831);
    press(3'b001, 4);
    check("wrap lo", {16'h0, disp_value}, 32'h270F);
    press(3'b001, 80);
    check("roll", {31'h0, $signed(disp_value) < 16'sh2704}, 32'h1);
    press(3'b100, 4);
    press(3'b100, 4);
    check("gain prompt", {29'h0, disp_prompt}, {29'h0, PR_GAIN});
    press(3'b001, 4);
    check("gain edit", {16'h0, disp_value}, 32'hFFFF);
    press(3'b100, 4);
    check("gain back", {29'h0, disp_prompt}, {29'h0, PR_GAIN});
    rd("gain", REG_GAIN, 32'hFFFFFFFF);
    press(3'b100, 4);
    check("run", {29'h0, disp_prompt}, {29'h0, PR_NONE});
    $display("test wrap done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
